// file: tx_fmt_pkg.sv
// constants, formats and states for the serial transmitter
// assumes a single 100 MHz clock and a synchronous 16x bit-rate pin
package tx_fmt_pkg;

    // ************************************************************
    // bit timing, counted in edges of the 16x transmit clock pin
    // ************************************************************
    localparam logic [3:0] TICKS_LAST_OF_BIT  = 4'hf;
    localparam logic [3:0] TICKS_LAST_OF_HALF = 4'h7;

    // ************************************************************
    // character format
    // ************************************************************
    localparam logic [2:0] LEN_BASE      = 3'h5;
    localparam logic [1:0] LEN_SEL_FIVE  = 2'h0;
    localparam int         DATA_MSB      = 7;

    typedef struct packed {
        logic       parity_disable;
        logic       two_stop_select;
        logic [1:0] char_length_select;
        logic       parity_even_select;
    } tx_format_t;

    localparam tx_format_t FORMAT_RESET = '{1'b0, 1'b0, 2'h0, 1'b0};

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_START  = 3'b001,
        ST_DATA   = 3'b010,
        ST_PARITY = 3'b011,
        ST_STOP1  = 3'b100,
        ST_STOP2  = 3'b101
    } tx_state_t;

    // ************************************************************
    // register port
    // ************************************************************
    localparam logic [3:0] OFS_INT_STATUS = 4'h0;
    localparam logic [3:0] OFS_INT_MASK   = 4'h4;
    localparam logic [3:0] OFS_LIVE       = 4'h8;
    localparam int         EV_CHAR_DONE   = 0;
    localparam int         EV_HOLD_FREE   = 1;
    localparam int         NUM_EVENTS     = 2;
    localparam logic [NUM_EVENTS-1:0] INT_RESET = 2'h0;

endpackage

// file: tx_bit_timer.sv
// divider from the 16x transmit clock pin to bit and half-bit enables
// assumes the pin is synchronous to CLK and slower than CLK/2
`timescale 1ns/1ps
`default_nettype none
module tx_bit_timer
    import tx_fmt_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk16_pin,
    input  wire logic       restart,
    output logic            tick,
    output logic            bit_end,
    output logic            half_end,
    output logic [3:0]      count
);
    logic       pin_prev_reg;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;

    // rising edge of the 16x pin is one phase tick
    assign tick     = clk16_pin & ~pin_prev_reg;
    assign bit_end  = tick & (cnt_reg == TICKS_LAST_OF_BIT);
    assign half_end = tick & (cnt_reg == TICKS_LAST_OF_HALF);
    assign count    = cnt_reg;
    assign cnt_next = restart ? 4'h0 : (tick ? cnt_reg + 4'h1 : cnt_reg);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_reg <= 1'b0;
            cnt_reg      <= 4'h0;
        end else begin
            pin_prev_reg <= clk16_pin;
            cnt_reg      <= cnt_next;
        end
    end

    a_bit_sixteen: assert property (@(posedge clk) disable iff (!rst_n)
        bit_end |-> (cnt_reg == 4'hf) && tick)
        else $error("bit end not on sixteenth tick");
endmodule // tx_bit_timer
`default_nettype wire

// file: tx_serializer.sv
// transmit half of an asynchronous serial port with its format latch
// assumes all pins synchronous to CLK; 16x pin from the system
//
// What this block does
// - buffer-empty flag high whenever holding register can take a character
// - buffer-empty output floats while status output enable is high
// - data strobe pulse captures the parallel inputs into holding register
// - idle transmitter starts the first character on data strobe rising edge
// - end-of-character rises after each full character, holds until next start
// - whole frame shifted out serially; line stays high when nothing sent
// - holding register accepts up to eight data bits
// - format selections load while control strobe high; may be tied high
// - parity disable drops the parity bit; stops follow last data bit
// - stop bits follow parity; low select one stop, high select two
// - two stops with five-bit characters gives one and a half stops
// - length select 00,01,10,11 gives five, six, seven, eight data bits
// - parity after data bits; low select odd, high select even
// - external reset clears transmit and format registers, sets line, end-of-char and empty high
// - buffer-empty flag driven while enable low, floating while high; end-of-char always driven
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tx_serializer
    import tx_fmt_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RESET_N,
    input  wire logic       EXTERNAL_RESET,
    input  wire logic       TX_CLOCK_16X,
    input  wire logic       DATA_STROBE,
    input  wire logic [7:0] TX_PARALLEL_IN,
    input  wire logic       CONTROL_STROBE,
    input  wire logic       PARITY_DISABLE,
    input  wire logic       TWO_STOP_SELECT,
    input  wire logic [1:0] CHAR_LENGTH_SELECT,
    input  wire logic       PARITY_EVEN_SELECT,
    input  wire logic       STATUS_OUTPUT_ENABLE,
    input  wire logic [3:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    output logic            SERIAL_OUT,
    output logic            END_OF_CHAR,
    output logic            TX_HOLDING_EMPTY,
    output logic            TX_HOLDING_EMPTY_OE,
    output logic            IRQ
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_sync1_reg;
    logic rst_n;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rst_sync1_reg <= 1'b0;
            rst_n         <= 1'b0;
        end else begin
            rst_sync1_reg <= 1'b1;
            rst_n         <= rst_sync1_reg;
        end
    end

    // ************************************************************
    // declarations
    // ************************************************************
    tx_format_t              fmt_in;
    tx_format_t              fmt_reg;
    tx_state_t               state_reg;
    tx_state_t               state_next;
    logic [7:0]              hold_reg;
    logic                    hold_full_reg;
    logic                    ds_prev_reg;
    logic [7:0]              shift_reg;
    logic [7:0]              shift_next;
    logic [2:0]              bit_idx_reg;
    logic                    parity_reg;
    logic                    short_stop_reg;
    logic                    eoc_reg;
    logic [NUM_EVENTS-1:0]   int_status_reg;
    logic [NUM_EVENTS-1:0]   int_mask_reg;
    logic                    tick;
    logic                    bit_end;
    logic                    half_end;
    logic [3:0]              tick_count;

    // ************************************************************
    // decode
    // ************************************************************
    wire        xr            = EXTERNAL_RESET;
    wire        ds_rise       = DATA_STROBE & ~ds_prev_reg;
    wire [2:0]  last_idx      = 3'(fmt_reg.char_length_select) + 3'h4;
    wire [7:0]  len_mask      = 8'hff >> (3'h3 - 3'(fmt_reg.char_length_select));
    wire [7:0]  load_data     = hold_reg & len_mask;
    wire        load_parity   = ^load_data ^ ~fmt_reg.parity_even_select;
    wire        last_data     = (bit_idx_reg == last_idx);
    wire        stop2_end     = short_stop_reg ? half_end : bit_end;
    wire        frame_done    = (state_reg == ST_STOP1 && bit_end && !fmt_reg.two_stop_select)
                              | (state_reg == ST_STOP2 && stop2_end);
    wire        go_idle_start = (state_reg == ST_IDLE) && hold_full_reg;
    wire        go_next_start = frame_done && hold_full_reg;
    wire        transfer      = go_idle_start | go_next_start;
    wire        wr_status     = REG_WR && (REG_ADDR == OFS_INT_STATUS);
    wire        wr_mask       = REG_WR && (REG_ADDR == OFS_INT_MASK);
    wire [NUM_EVENTS-1:0] events;
    wire [7:0]  rd_mux;

    assign fmt_in = '{PARITY_DISABLE, TWO_STOP_SELECT, CHAR_LENGTH_SELECT,
                      PARITY_EVEN_SELECT};
    assign events[EV_CHAR_DONE] = frame_done;
    assign events[EV_HOLD_FREE] = transfer;

    assign rd_mux = (REG_ADDR == OFS_INT_STATUS) ? {6'h0, int_status_reg} :
                    (REG_ADDR == OFS_INT_MASK)   ? {6'h0, int_mask_reg}   :
                    (REG_ADDR == OFS_LIVE)       ? {3'h0, state_reg, eoc_reg,
                                                    ~hold_full_reg} :
                                                   8'h00;

    // ************************************************************
    // bit timing
    // ************************************************************
    tx_bit_timer u_timer (
        .clk       (CLK),
        .rst_n     (rst_n),
        .clk16_pin (TX_CLOCK_16X),
        .restart   (transfer),
        .tick      (tick),
        .bit_end   (bit_end),
        .half_end  (half_end),
        .count     (tick_count)
    );

    // ************************************************************
    // frame sequencer
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        if (transfer) begin
            state_next = ST_START;
            shift_next = load_data;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    state_next = ST_IDLE;
                end
                ST_START: begin
                    if (bit_end)
                        state_next = ST_DATA;
                end
                ST_DATA: begin
                    if (bit_end) begin
                        shift_next = shift_reg >> 1;
                        if (!last_data)
                            state_next = ST_DATA;
                        else if (fmt_reg.parity_disable)
                            state_next = ST_STOP1;
                        else
                            state_next = ST_PARITY;
                    end
                end
                ST_PARITY: begin
                    if (bit_end)
                        state_next = ST_STOP1;
                end
                ST_STOP1: begin
                    if (bit_end)
                        state_next = fmt_reg.two_stop_select ? ST_STOP2 : ST_IDLE;
                end
                ST_STOP2: begin
                    if (stop2_end)
                        state_next = ST_IDLE;
                end
                default: begin
                    state_next = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
        end else if (xr) begin
            state_reg <= ST_IDLE;
            shift_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
        end
    end

    // ************************************************************
    // bit counter and per-character latches
    // ************************************************************
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            bit_idx_reg    <= 3'h0;
            parity_reg     <= 1'b0;
            short_stop_reg <= 1'b0;
        end else if (xr || transfer) begin
            bit_idx_reg    <= 3'h0;
            parity_reg     <= xr ? 1'b0 : load_parity;
            short_stop_reg <= xr ? 1'b0 : (fmt_reg.char_length_select == LEN_SEL_FIVE);
        end else if (state_reg == ST_DATA && bit_end) begin
            bit_idx_reg    <= bit_idx_reg + 3'h1;
        end
    end

    // ************************************************************
    // holding register and format latch
    // ************************************************************
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
            ds_prev_reg   <= 1'b0;
            fmt_reg       <= FORMAT_RESET;
        end else if (xr) begin
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
            ds_prev_reg   <= DATA_STROBE;
            fmt_reg       <= FORMAT_RESET;
        end else begin
            ds_prev_reg <= DATA_STROBE;
            if (DATA_STROBE)
                hold_reg <= TX_PARALLEL_IN;
            if (ds_rise)
                hold_full_reg <= 1'b1;
            else if (transfer)
                hold_full_reg <= 1'b0;
            if (CONTROL_STROBE)
                fmt_reg <= fmt_in;
        end
    end

    // ************************************************************
    // pin outputs
    // ************************************************************
    logic serial_next;

    always_comb begin
        unique case (state_next)
            ST_START:  serial_next = 1'b0;
            ST_DATA:   serial_next = shift_next[0];
            ST_PARITY: serial_next = (transfer ? load_parity : parity_reg);
            default:   serial_next = 1'b1;
        endcase
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SERIAL_OUT          <= 1'b1;
            eoc_reg             <= 1'b1;
            TX_HOLDING_EMPTY    <= 1'b1;
            TX_HOLDING_EMPTY_OE <= 1'b1;
        end else if (xr) begin
            SERIAL_OUT          <= 1'b1;
            eoc_reg             <= 1'b1;
            TX_HOLDING_EMPTY    <= 1'b1;
            TX_HOLDING_EMPTY_OE <= ~STATUS_OUTPUT_ENABLE;
        end else begin
            SERIAL_OUT          <= serial_next;
            // end flag pulses for one cycle even when the next start follows at once
            if (frame_done)
                eoc_reg <= 1'b1;
            else if (transfer || state_reg == ST_START)
                eoc_reg <= 1'b0;
            TX_HOLDING_EMPTY    <= ~(hold_full_reg | ds_rise);
            TX_HOLDING_EMPTY_OE <= ~STATUS_OUTPUT_ENABLE;
        end
    end

    assign END_OF_CHAR = eoc_reg;

    // ************************************************************
    // interrupt status, mask and read port
    // ************************************************************
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            int_status_reg <= INT_RESET;
            int_mask_reg   <= INT_RESET;
            IRQ            <= 1'b0;
            REG_RDATA      <= 8'h00;
        end else begin
            // a new event wins over a same-cycle write-one clear
            int_status_reg <= (int_status_reg & ~({NUM_EVENTS{wr_status}}
                               & REG_WDATA[NUM_EVENTS-1:0])) | events;
            if (wr_mask)
                int_mask_reg <= REG_WDATA[NUM_EVENTS-1:0];
            IRQ       <= |(int_status_reg & int_mask_reg);
            REG_RDATA <= REG_RD ? rd_mux : 8'h00;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    a_idle_line_high: assert property (@(posedge CLK) disable iff (!rst_n)
        (state_reg == ST_IDLE) && $past(state_reg == ST_IDLE) |-> SERIAL_OUT)
        else $error("line not marking while idle");

    a_start_bit_low: assert property (@(posedge CLK) disable iff (!rst_n)
        (state_reg == ST_START) |-> !SERIAL_OUT && (!eoc_reg || $past(frame_done)))
        else $error("start bit not low or end flag still high");

    a_start_length: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        (state_reg == ST_START) && bit_end |=> (state_reg == ST_DATA))
        else $error("start bit did not end after sixteen ticks");

    a_strobe_fills: assert property (@(posedge CLK) disable iff (!rst_n)
        ds_rise && !xr |=> hold_full_reg ##1 !TX_HOLDING_EMPTY)
        else $error("strobe did not fill holding register");

    a_empty_follows: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        !hold_full_reg && !ds_rise |=> TX_HOLDING_EMPTY)
        else $error("empty flag low while holding register free");

    a_status_float: assert property (@(posedge CLK) disable iff (!rst_n)
        STATUS_OUTPUT_ENABLE |=> !TX_HOLDING_EMPTY_OE)
        else $error("status flag driven while enable high");

    a_eoc_holds: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        eoc_reg && !transfer && (state_reg != ST_START) |=> eoc_reg)
        else $error("end flag dropped without a new character");

    a_eoc_pulse: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        frame_done |=> eoc_reg)
        else $error("end flag not raised after a full character");

    a_parity_skip: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        (state_reg == ST_DATA) && bit_end && last_data && fmt_reg.parity_disable
        |=> (state_reg == ST_STOP1) && SERIAL_OUT)
        else $error("parity bit sent while disabled");

    a_format_load: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        CONTROL_STROBE |=> fmt_reg == $past(fmt_in))
        else $error("format not latched under control strobe");

    a_half_stop: assert property (@(posedge CLK) disable iff (!rst_n || xr)
        (state_reg == ST_STOP2) && short_stop_reg && half_end && !hold_full_reg
        |=> (state_reg == ST_IDLE) && eoc_reg)
        else $error("short second stop not ended at half bit");

    a_reset_marks: assert property (@(posedge CLK) disable iff (!rst_n)
        xr |=> SERIAL_OUT && eoc_reg && TX_HOLDING_EMPTY && (state_reg == ST_IDLE))
        else $error("external reset did not mark the line");

    c_char_sent:   cover property (@(posedge CLK) disable iff (!rst_n) frame_done);
    c_back_to_back: cover property (@(posedge CLK) disable iff (!rst_n) go_next_start);
    c_half_stop:   cover property (@(posedge CLK) disable iff (!rst_n)
        (state_reg == ST_STOP2) && short_stop_reg && half_end);
    c_irq_raised:  cover property (@(posedge CLK) disable iff (!rst_n) $rose(IRQ));

endmodule // tx_serializer
`default_nettype wire

// file: tx_line_monitor.sv
// remote receiver model: samples the serial line at mid-bit
// assumes the 16x clock runs at CLK/4, so one bit lasts 64 CLK cycles
`timescale 1ns/1ps
`default_nettype none
module tx_line_monitor (
    input  wire logic        clk,
    input  wire logic        line,
    input  wire logic        eoc,
    input  wire logic [3:0]  nsamp,
    output logic      [11:0] bits,
    output int               len,
    output int               nframes
);
    int c;
    logic [11:0] cur;
    initial begin
        bits = '0;
        len = 0;
        nframes = 0;
        forever begin
            @(posedge clk);
            #1;
            if (line === 1'b0) begin
                cur = '0;
                for (c = 1; c < 2000; c++) begin
                    @(posedge clk);
                    #1;
                    // mid-bit sample, start bit lands in bit 0
                    if (c % 64 == 32 && c / 64 < nsamp) cur[c / 64] = line;
                    if (eoc === 1'b1) break;
                end
                // frame bits stay put until the next frame has ended
                bits = cur;
                len = c;
                nframes++;
            end
        end
    end
endmodule // tx_line_monitor
`default_nettype wire

// file: tx_serializer_tb.sv
// self-checking bench for the serial transmitter
// assumes tx_fmt_pkg, tx_serializer and tx_line_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module tx_serializer_tb;
    import tx_fmt_pkg::*;
    logic CLK = 0, RESET_N = 0, EXTERNAL_RESET = 0, TX_CLOCK_16X = 0, DATA_STROBE = 0;
    logic [7:0] TX_PARALLEL_IN = '0, REG_WDATA = '0, REG_RDATA;
    logic CONTROL_STROBE = 0, PARITY_DISABLE = 0, TWO_STOP_SELECT = 0, PARITY_EVEN_SELECT = 0;
    logic [1:0] CHAR_LENGTH_SELECT = '0;
    logic STATUS_OUTPUT_ENABLE = 0, REG_WR = 0, REG_RD = 0;
    logic [3:0] REG_ADDR = '0, nsamp = 4'h9;
    logic SERIAL_OUT, END_OF_CHAR, TX_HOLDING_EMPTY, TX_HOLDING_EMPTY_OE, IRQ;
    logic [11:0] bits;
    logic [7:0] d;
    int len, nframes, n_errors = 0, tests_run = 0, cycles = 0, tdiv = 0;

    tx_serializer dut (.CLK(CLK), .RESET_N(RESET_N), .EXTERNAL_RESET(EXTERNAL_RESET),
        .TX_CLOCK_16X(TX_CLOCK_16X), .DATA_STROBE(DATA_STROBE), .TX_PARALLEL_IN(TX_PARALLEL_IN),
        .CONTROL_STROBE(CONTROL_STROBE), .PARITY_DISABLE(PARITY_DISABLE),
        .TWO_STOP_SELECT(TWO_STOP_SELECT), .CHAR_LENGTH_SELECT(CHAR_LENGTH_SELECT),
        .PARITY_EVEN_SELECT(PARITY_EVEN_SELECT), .STATUS_OUTPUT_ENABLE(STATUS_OUTPUT_ENABLE),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .SERIAL_OUT(SERIAL_OUT), .END_OF_CHAR(END_OF_CHAR),
        .TX_HOLDING_EMPTY(TX_HOLDING_EMPTY), .TX_HOLDING_EMPTY_OE(TX_HOLDING_EMPTY_OE), .IRQ(IRQ));
    tx_line_monitor mon (.clk(CLK), .line(SERIAL_OUT), .eoc(END_OF_CHAR), .nsamp(nsamp),
        .bits(bits), .len(len), .nframes(nframes));

    // ************************************************************
    // clocks and watchdog
    // ************************************************************
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        tdiv <= tdiv + 1;
        TX_CLOCK_16X <= tdiv[1];
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_errors++;
            give_verdict();
        end
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_WDATA <= v;
        REG_WR <= 1'b1;
        @(posedge CLK);
        REG_WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK);
        REG_RD <= 1'b0;
        #1 d = REG_RDATA;
    endtask
    // expected frame: start, data lsb first, parity, first stop; length in CLK cycles
    task automatic frame(input tx_format_t f, input logic [7:0] v, output logic [11:0] e,
                         output int el);
        int n;
        int p;
        logic par;
        n = 5 + f.char_length_select;
        p = f.parity_disable ? 0 : 1;
        par = ~f.parity_even_select;
        e = '0;
        for (int i = 0; i < n; i++) begin
            e[1 + i] = v[i];
            par ^= v[i];
        end
        if (p == 1) e[1 + n] = par;
        e[1 + n + p] = 1'b1;
        el = (1 + n + p) * 64 + (f.two_stop_select ? (n == 5 ? 96 : 128) : 64);
        nsamp <= 4'(2 + n + p);
    endtask
    task automatic strobe(input tx_format_t f, input logic [7:0] v, input logic ld);
        @(posedge CLK);
        if (ld) {PARITY_DISABLE, TWO_STOP_SELECT, CHAR_LENGTH_SELECT, PARITY_EVEN_SELECT} <= f;
        CONTROL_STROBE <= ld;
        @(posedge CLK);
        CONTROL_STROBE <= 1'b0;
        DATA_STROBE <= 1'b1;
        TX_PARALLEL_IN <= v;
        repeat (2) @(posedge CLK);
        DATA_STROBE <= 1'b0;
    endtask
    task automatic await_frame(input int old, input tx_format_t f, input logic [7:0] v);
        logic [11:0] e;
        int el;
        frame(f, v, e, el);
        for (int i = 0; i < 3000 && nframes == old; i++) wait_clk(1);
        check("frame seen", {31'h0, nframes != old}, 32'h1);
        check("frame bits", {20'h0, bits}, {20'h0, e});
        check("frame length ok", {31'h0, len >= el - 8 && len <= el + 8}, 32'h1);
    endtask
    task automatic send(input tx_format_t f, input logic [7:0] v, input logic ld);
        int old;
        old = nframes;
        strobe(f, v, ld);
        await_frame(old, f, v);
        wait_clk(2);
        check("idle line eoc empty", {SERIAL_OUT, END_OF_CHAR, TX_HOLDING_EMPTY}, 3'h7);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_formats();
        tx_format_t tbl[6] = '{5'b00000, 5'b01001, 5'b10010, 5'b01101, 5'b11110, 5'b00111};
        logic [7:0] dat[6] = '{8'hb5, 8'h3a, 8'hc6, 8'h5d, 8'ha7, 8'h81};
        for (int i = 0; i < 6; i++) send(tbl[i], dat[i], 1'b1);
    endtask
    task automatic t_back_to_back();
        int old;
        old = nframes;
        strobe(5'b00110, 8'h4e, 1'b1);
        wait_clk(3);
        check("empty after transfer", {31'h0, TX_HOLDING_EMPTY}, 32'h1);
        strobe(5'b00110, 8'hd3, 1'b0);
        wait_clk(1);
        check("empty while loaded", {31'h0, TX_HOLDING_EMPTY}, 32'h0);
        await_frame(old, 5'b00110, 8'h4e);
        await_frame(old + 1, 5'b00110, 8'hd3);
    endtask
    task automatic t_status_enable();
        STATUS_OUTPUT_ENABLE <= 1'b1;
        wait_clk(2);
        check("empty flag floats", {31'h0, TX_HOLDING_EMPTY_OE}, 32'h0);
        STATUS_OUTPUT_ENABLE <= 1'b0;
        wait_clk(2);
        check("empty flag driven", {31'h0, TX_HOLDING_EMPTY_OE}, 32'h1);
    endtask
    task automatic t_irq();
        wr(OFS_INT_STATUS, 8'h03);
        wr(OFS_INT_MASK, 8'h00);
        send(5'b00010, 8'h66, 1'b1);
        check("masked irq", {31'h0, IRQ}, 32'h0);
        rd(OFS_INT_STATUS);
        check("done event", {24'h0, d}, 32'h3);
        wr(OFS_INT_MASK, 8'h01);
        wait_clk(2);
        check("irq raised", {31'h0, IRQ}, 32'h1);
        rd(OFS_LIVE);
        check("live idle", {24'h0, d}, 32'h3);
        rd(4'hc);
        check("unmapped read", {24'h0, d}, 32'h0);
        wr(OFS_INT_STATUS, 8'h01);
        wait_clk(2);
        check("irq cleared", {31'h0, IRQ}, 32'h0);
    endtask
    task automatic t_ext_reset();
        strobe(5'b01111, 8'h00, 1'b1);
        wait_clk(150);
        EXTERNAL_RESET <= 1'b1;
        wait_clk(2);
        check("reset outputs", {SERIAL_OUT, END_OF_CHAR, TX_HOLDING_EMPTY}, 3'h7);
        EXTERNAL_RESET <= 1'b0;
        wait_clk(4);
        send(FORMAT_RESET, 8'he9, 1'b0);
    endtask

    initial begin
        wait_clk(2);
        RESET_N <= 1'b1;
        wait_clk(3);
        check("reset idle", {SERIAL_OUT, END_OF_CHAR, TX_HOLDING_EMPTY, IRQ}, 4'he);
        t_formats();
        t_back_to_back();
        t_status_enable();
        t_irq();
        t_ext_reset();
        give_verdict();
    end
endmodule // tx_serializer_tb
`default_nettype wire
